// file: vcd_top.sv
// Functional notes
// RULE1: event when vector distance exceeds threshold past the debounce count.
// RULE2: reference is the internal copy or the initial-reference registers.
// RULE3: internal reference values are never readable over the bus.
// RULE4: latch select 0 makes the flag follow the debounced condition.
// RULE5: latch select 1 holds the flag until interrupt source is read.
// RULE6: source select 0 captures the live sample at enable.
// RULE7: source select 1 loads the initial-reference registers at enable.
// RULE8: hold select 0 replaces the reference with the sample on trigger.
// RULE9: hold select 1 keeps the reference unchanged on trigger.
// RULE10: both selects set make initial-reference writes act at once.
// RULE11: enable starts detection and loads reference; clearing stops it.
// RULE12: host keeps output sample rate at or below 400 Hz.
// RULE13: configuration bits: reserved, latch, source, hold, enable, reserved; reset zero.
// RULE14: debounce period is count times one sample period.
// RULE15: below threshold the counter decrements or clears per clear select.
// RULE16: threshold is 13-bit unsigned, five upper and eight lower bits.
// RULE17: initial references are signed 14-bit, six upper and eight lower.
// RULE18: condition and counter advance once per new sample.
// RULE19: compare squared distance against squared threshold.
//
// The AXI4-Lite slave port was chosen for this implementation.
`include "vcd_regs.svh"
`default_nettype none
module vcd_top #(
    parameter int AW = 12,
    parameter int CW = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // acceleration samples
    input  wire logic              smp_valid,
    input  wire vcd_pkg::vcd_axis_t smp_x,
    input  wire vcd_pkg::vcd_axis_t smp_y,
    input  wire vcd_pkg::vcd_axis_t smp_z,
    // event outputs
    output logic                   event_flag_q,
    output logic                   irq_q,
    // axi4-lite write address
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    import vcd_pkg::*;

    function automatic vcd_reg_t reg_idx(input logic [AW-1:0] addr);
        return vcd_reg_t'(addr >> 2);
    endfunction

    function automatic logic idx_ok(input logic [AW-1:0] addr);
        return (addr >> 2) <= (AW)'(8'hff);
    endfunction

    // registers
    vcd_reg_t  cfg_q;
    vcd_reg_t  ths_msb_q;
    vcd_reg_t  ths_lsb_q;
    vcd_reg_t  cnt_lim_q;
    vcd_axis_t initx_q;
    vcd_axis_t inity_q;
    vcd_axis_t initz_q;
    vcd_reg_t  irq_sts_q;
    vcd_reg_t  irq_en_q;
    vcd_vec_t  ref_q;
    vcd_vec_t  last_q;
    logic      en_prev_q;
    logic      latch_q;

    // bus state
    logic          aw_full_q;
    logic          w_full_q;
    logic [AW-1:0] waddr_q;
    logic [31:0]   wdata_q;
    logic          wlane_q;
    logic          do_wr;
    vcd_reg_t      widx;
    vcd_reg_t      wval;
    logic          rd_hs;
    logic          int_src_rd;
    vcd_reg_t      ridx;
    vcd_reg_t      rval;
    logic          rhit;

    // detector signals
    vcd_cmp_if     cmp ();
    logic          en;
    logic          initm;
    logic          updm;
    logic          ele;
    logic [CW-1:0] dbc_cnt;
    logic          rt;
    logic          trig;
    logic          fall;
    vcd_vec_t      init_vec;
    vcd_reg_t      irq_set;
    vcd_reg_t      irq_clr;

    assign en       = cfg_q[`VCD_CFG_EN];
    assign initm    = cfg_q[`VCD_CFG_INITM];
    assign updm     = cfg_q[`VCD_CFG_UPDM];
    assign ele      = cfg_q[`VCD_CFG_ELE];
    assign init_vec = '{x: initx_q, y: inity_q, z: initz_q};

    // write channel: address and data taken in either order
    assign do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
    assign widx  = reg_idx(waddr_q);
    assign wval  = wdata_q[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q     <= 1'b0;
            s_axi_awready <= 1'b1;
            waddr_q       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q     <= 1'b1;
            s_axi_awready <= 1'b0;
            waddr_q       <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_full_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q     <= 1'b0;
            s_axi_wready <= 1'b1;
            wdata_q      <= '0;
            wlane_q      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_q     <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wlane_q      <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_full_q     <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `VCD_RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= rhit_w(widx) && idx_ok(waddr_q) ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic rhit_w(input vcd_reg_t i);
        return i == `VCD_IDX_INT_SRC || (i >= `VCD_IDX_CFG && i <= `VCD_IDX_INITZ_LSB)
            || (i >= `VCD_IDX_IRQ_STS && i <= `VCD_IDX_IRQ_EN);
    endfunction

    // RULE13: configuration layout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q     <= `VCD_RST8;
            ths_msb_q <= `VCD_RST8;
            ths_lsb_q <= `VCD_RST8;
            cnt_lim_q <= `VCD_RST8;
        end else if (do_wr && wlane_q) begin
            case (widx)
                `VCD_IDX_CFG:     cfg_q     <= wval & `VCD_CFG_WMASK;
                // RULE16: threshold halves
                `VCD_IDX_THS_MSB: ths_msb_q <= wval & `VCD_THS_MSB_MASK;
                `VCD_IDX_THS_LSB: ths_lsb_q <= wval;
                `VCD_IDX_CNT:     cnt_lim_q <= wval;
                default: begin
                end
            endcase
        end
    end

    // RULE17: signed initial references
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            initx_q <= '0;
            inity_q <= '0;
            initz_q <= '0;
        end else if (do_wr && wlane_q) begin
            case (widx)
                `VCD_IDX_INITX_MSB: initx_q[13:8] <= wval[5:0];
                `VCD_IDX_INITX_LSB: initx_q[7:0]  <= wval;
                `VCD_IDX_INITY_MSB: inity_q[13:8] <= wval[5:0];
                `VCD_IDX_INITY_LSB: inity_q[7:0]  <= wval;
                `VCD_IDX_INITZ_MSB: initz_q[13:8] <= wval[5:0];
                `VCD_IDX_INITZ_LSB: initz_q[7:0]  <= wval;
                default: begin
                end
            endcase
        end
    end

    // read channel
    assign rd_hs      = s_axi_arvalid && s_axi_arready;
    assign ridx       = reg_idx(s_axi_araddr);
    assign int_src_rd = rd_hs && ridx == `VCD_IDX_INT_SRC;

    // RULE3: reference copy not mapped
    always_comb begin
        rhit = idx_ok(s_axi_araddr) && rhit_w(ridx) && ridx != `VCD_IDX_IRQ_CLR;
        case (ridx)
            `VCD_IDX_INT_SRC:   rval = vcd_reg_t'({event_flag_q, 1'b0}) & `VCD_IRQ_MASK;
            `VCD_IDX_CFG:       rval = cfg_q;
            `VCD_IDX_THS_MSB:   rval = ths_msb_q;
            `VCD_IDX_THS_LSB:   rval = ths_lsb_q;
            `VCD_IDX_CNT:       rval = cnt_lim_q;
            `VCD_IDX_INITX_MSB: rval = {2'b00, initx_q[13:8]};
            `VCD_IDX_INITX_LSB: rval = initx_q[7:0];
            `VCD_IDX_INITY_MSB: rval = {2'b00, inity_q[13:8]};
            `VCD_IDX_INITY_LSB: rval = inity_q[7:0];
            `VCD_IDX_INITZ_MSB: rval = {2'b00, initz_q[13:8]};
            `VCD_IDX_INITZ_LSB: rval = initz_q[7:0];
            `VCD_IDX_IRQ_STS:   rval = irq_sts_q;
            `VCD_IDX_IRQ_EN:    rval = irq_en_q;
            default:            rval = `VCD_RST8;
        endcase
        if (!rhit) begin
            rval = `VCD_RST8;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `VCD_RESP_OKAY;
        end else if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rval};
            s_axi_rresp   <= rhit ? `VCD_RESP_OKAY : `VCD_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // last sample seen, for capture at enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= '0;
        end else if (smp_valid) begin
            last_q <= '{x: smp_x, y: smp_y, z: smp_z};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en;
        end
    end

    // RULE11: load reference on enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_q <= '0;
        end else if (en && !en_prev_q) begin
            // RULE6: live sample / RULE7: initial registers
            ref_q <= initm ? init_vec : last_q;
        // RULE8: follow sample on trigger
        end else if (trig && !updm) begin
            ref_q <= last_q;
        end
        // RULE9: hold keeps ref_q untouched
    end

    // RULE2: reference select
    // RULE10: initial registers act live
    assign cmp.refv = (initm && updm) ? init_vec : ref_q;
    assign cmp.smp  = '{x: smp_x, y: smp_y, z: smp_z};
    assign cmp.ths  = {ths_msb_q[4:0], ths_lsb_q};

    vcd_dist u_dist (
        .c (cmp.cmp)
    );

    // RULE1: debounced trigger
    vcd_debounce #(
        .CW (CW)
    ) u_dbc (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .en       (en && en_prev_q),
        .smp      (smp_valid),
        .cond     (cmp.above),
        .limit    (cnt_lim_q[CW-1:0]),
        .clr_mode (ths_msb_q[`VCD_THS_DBCNTM]),
        .cnt_q    (dbc_cnt),
        .rt_q     (rt),
        .trig_q   (trig),
        .fall_q   (fall)
    );

    // RULE5: latched until source read, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= 1'b0;
        end else if (trig && ele) begin
            latch_q <= 1'b1;
        end else if (int_src_rd || !ele) begin
            latch_q <= 1'b0;
        end
    end

    // RULE4: real-time or latched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_flag_q <= 1'b0;
        end else if (ele) begin
            event_flag_q <= trig || (latch_q && !int_src_rd);
        end else begin
            event_flag_q <= rt;
        end
    end

    // interrupt status, clear register, enable
    always_comb begin
        irq_set = `VCD_RST8;
        irq_set[`VCD_IRQ_TRIG] = trig;
        irq_set[`VCD_IRQ_FALL] = fall;
        irq_clr = (do_wr && wlane_q && widx == `VCD_IDX_IRQ_CLR) ? wval : `VCD_RST8;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_sts_q <= `VCD_RST8;
            irq_en_q  <= `VCD_RST8;
            irq_q     <= 1'b0;
        end else begin
            irq_sts_q <= ((irq_sts_q & ~irq_clr) | irq_set) & `VCD_IRQ_MASK;
            if (do_wr && wlane_q && widx == `VCD_IDX_IRQ_EN) begin
                irq_en_q <= wval & `VCD_IRQ_MASK;
            end
            irq_q <= |(irq_sts_q & irq_en_q);
        end
    end

    // debounce count visible only inside
    logic unused_ok;
    assign unused_ok = ^{dbc_cnt, wdata_q[31:8]};
endmodule
`default_nettype wire

// file: vcd_regs.svh
`ifndef VCD_REGS_SVH
`define VCD_REGS_SVH

// register indices; byte address is four times the index
`define VCD_IDX_INT_SRC   8'h0c
`define VCD_IDX_CFG       8'h5f
`define VCD_IDX_THS_MSB   8'h60
`define VCD_IDX_THS_LSB   8'h61
`define VCD_IDX_CNT       8'h62
`define VCD_IDX_INITX_MSB 8'h63
`define VCD_IDX_INITX_LSB 8'h64
`define VCD_IDX_INITY_MSB 8'h65
`define VCD_IDX_INITY_LSB 8'h66
`define VCD_IDX_INITZ_MSB 8'h67
`define VCD_IDX_INITZ_LSB 8'h68
`define VCD_IDX_IRQ_STS   8'h70
`define VCD_IDX_IRQ_CLR   8'h71
`define VCD_IDX_IRQ_EN    8'h72

// configuration fields
`define VCD_CFG_ELE       6
`define VCD_CFG_INITM     5
`define VCD_CFG_UPDM      4
`define VCD_CFG_EN        3
`define VCD_CFG_WMASK     8'h78
`define VCD_THS_DBCNTM    7
`define VCD_THS_MSB_MASK  8'h9f
`define VCD_INIT_MSB_MASK 8'h3f
`define VCD_INT_SRC_VECM  1

// interrupt status bits
`define VCD_IRQ_TRIG      0
`define VCD_IRQ_FALL      1
`define VCD_IRQ_MASK      8'h03

`define VCD_RST8          8'h00
`define VCD_RESP_OKAY     2'b00
`define VCD_RESP_SLVERR   2'b10

`endif

// file: vcd_pkg.sv
`default_nettype none
package vcd_pkg;
    typedef logic signed [13:0] vcd_axis_t;
    typedef logic [12:0]        vcd_ths_t;
    typedef logic [7:0]         vcd_reg_t;
    typedef struct packed {
        vcd_axis_t x;
        vcd_axis_t y;
        vcd_axis_t z;
    } vcd_vec_t;
endpackage
`default_nettype wire

// file: vcd_cmp_if.sv
`default_nettype none
interface vcd_cmp_if;
    import vcd_pkg::*;
    vcd_vec_t smp;
    vcd_vec_t refv;
    vcd_ths_t ths;
    logic     above;
    modport drv (output smp, output refv, output ths, input above);
    modport cmp (input smp, input refv, input ths, output above);
endinterface
`default_nettype wire

// file: vcd_dist.sv
`default_nettype none
module vcd_dist (
    // sample, reference, threshold
    vcd_cmp_if.cmp c
);
    import vcd_pkg::*;

    function automatic logic [27:0] sq_diff(input vcd_axis_t a, input vcd_axis_t b);
        logic signed [14:0] d;
        logic [14:0]        m;
        d = $signed({a[13], a}) - $signed({b[13], b});
        m = d[14] ? 15'(-d) : 15'(d);
        return 28'({13'h0000, m} * {13'h0000, m});
    endfunction

    logic [29:0] sum;
    logic [25:0] thsq;

    // RULE19: squared compare
    always_comb begin
        sum = 30'(sq_diff(c.smp.x, c.refv.x)) + 30'(sq_diff(c.smp.y, c.refv.y))
            + 30'(sq_diff(c.smp.z, c.refv.z));
        thsq = 26'({13'h0000, c.ths} * {13'h0000, c.ths});
        // RULE1: distance above threshold
        c.above = sum > {4'h0, thsq};
    end
endmodule
`default_nettype wire

// file: vcd_debounce.sv
`default_nettype none
module vcd_debounce #(
    parameter int CW = 8
) (
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // control
    input  wire logic          en,
    input  wire logic          smp,
    input  wire logic          cond,
    input  wire logic [CW-1:0] limit,
    input  wire logic          clr_mode,
    // state
    output logic      [CW-1:0] cnt_q,
    output logic               rt_q,
    output logic               trig_q,
    output logic               fall_q
);
    logic [CW-1:0] cnt_d;

    always_comb begin
        if (cond) begin
            cnt_d = (cnt_q < limit) ? CW'(cnt_q + 1'b1) : cnt_q;
        // RULE15: decrement or clear
        end else if (clr_mode || cnt_q == '0) begin
            cnt_d = '0;
        end else begin
            cnt_d = CW'(cnt_q - 1'b1);
        end
    end

    // RULE18: one step per sample
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            cnt_q <= '0;
        end else if (smp) begin
            cnt_q <= cnt_d;
        end
    end

    // RULE4: real-time debounced flag
    always_ff @(posedge aclk) begin
        if (!aresetn || !en) begin
            rt_q   <= 1'b0;
            trig_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            trig_q <= 1'b0;
            fall_q <= 1'b0;
            // RULE14: count of samples
            if (smp && cond && cnt_d >= limit && !rt_q) begin
                rt_q   <= 1'b1;
                trig_q <= 1'b1;
            end else if (smp && !cond && cnt_d == '0 && rt_q) begin
                rt_q   <= 1'b0;
                fall_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: vcd_monitor.sv
`include "vcd_regs.svh"
`default_nettype none
module vcd_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // detector
    input wire logic        smp_valid,
    input wire logic        event_flag_q,
    input wire logic        irq_q,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_idle_a: assert property (
        $rose(aresetn) |-> !event_flag_q && !irq_q && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy after reset");
    flag_per_sample_a: assert property (
        $rose(event_flag_q) |-> $past(smp_valid, 2))
        else $error("flag rose without a sample");
    read_upper_a: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("read data above byte not zero");
    err_data_a: assert property (
        s_axi_rvalid && s_axi_rresp == `VCD_RESP_SLVERR |-> s_axi_rdata == 32'h00000000)
        else $error("refused read carries data");
    b_latency_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response late");
    b_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_latency_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    r_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    aw_block_a: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2] ##0 !s_axi_wready)
        else $error("address taken while write open");

    flag_seen_c: cover property ($rose(event_flag_q));
    irq_seen_c: cover property ($rose(irq_q));
    slverr_seen_c: cover property (s_axi_rvalid && s_axi_rresp == `VCD_RESP_SLVERR);
endmodule

bind vcd_top vcd_monitor i_vcd_monitor (
    .aclk, .aresetn, .smp_valid, .event_flag_q, .irq_q,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// file: accel_vector_change_detector_tb.sv
`include "vcd_regs.svh"
`default_nettype none
module accel_vector_change_detector_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import vcd_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        smp_valid = 1'b0;
    vcd_axis_t   smp_x = '0, smp_y = '0, smp_z = '0;
    logic        event_flag_q, irq_q;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc = 0;

    vcd_top i_vcd_top (
        .aclk, .aresetn, .smp_valid, .smp_x, .smp_y, .smp_z, .event_flag_q, .irq_q,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready
    );

    always #12.5 aclk = ~aclk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    function automatic logic [11:0] ad(input logic [7:0] i);
        return {2'h0, i, 2'h0};
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = `VCD_RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr <= ad(i);
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge aclk);
        chk("bresp", 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = `VCD_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= ad(i);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (!s_axi_rvalid) @(posedge aclk);
        chk("rresp", 32'(er), 32'(s_axi_rresp));
        chk("rdata", {24'h000000, e}, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask

    task automatic fl(input logic e);
        repeat (2) @(posedge aclk);
        chk("event_flag_q", 32'(e), 32'(event_flag_q));
    endtask

    task automatic iq(input logic e);
        repeat (2) @(posedge aclk);
        chk("irq_q", 32'(e), 32'(irq_q));
    endtask

    // sparse sample strobes
    // one strobed sample, then the flag once settled
    task automatic smp(input int x, input int y, input int z, input logic e);
        @(posedge aclk);
        smp_x <= 14'(x);
        smp_y <= 14'(y);
        smp_z <= 14'(z);
        smp_valid <= 1'b1;
        @(posedge aclk);
        smp_valid <= 1'b0;
        repeat (3) @(posedge aclk);
        fl(e);
    endtask

    logic [4:0] pat = 5'h1b;

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`VCD_IDX_CFG, 8'h00);
        wr(`VCD_IDX_CFG, 8'h87);
        rd(`VCD_IDX_CFG, 8'h00);
        rd(8'h10, 8'h00, `VCD_RESP_SLVERR);
        wr(8'h10, 8'h55, `VCD_RESP_SLVERR);
        rd(`VCD_IDX_IRQ_CLR, 8'h00, `VCD_RESP_SLVERR);
        $display("test registers done");

        wr(`VCD_IDX_THS_LSB, 8'h64);
        wr(`VCD_IDX_CNT, 8'h02);
        smp(1000, 0, 0, 1'b0);
        wr(`VCD_IDX_CFG, 8'h18);
        smp(1050, 0, 0, 1'b0);
        smp(1101, 0, 0, 1'b0);
        smp(1060, 60, -60, 1'b1);
        smp(1100, 0, 0, 1'b1);
        smp(1000, 0, 0, 1'b0);
        rd(8'h69, 8'h00, `VCD_RESP_SLVERR);
        wr(`VCD_IDX_THS_MSB, 8'h80);
        wr(`VCD_IDX_CNT, 8'h03);
        for (int k = 4; k >= 0; k--) smp(pat[k] ? 1200 : 1000, 0, 0, 1'b0);
        smp(1200, 0, 0, 1'b1);
        wr(`VCD_IDX_CFG, 8'h00);
        fl(1'b0);
        $display("test debounce done");

        rd(`VCD_IDX_IRQ_STS, 8'h03);
        wr(`VCD_IDX_IRQ_CLR, 8'h03);
        rd(`VCD_IDX_IRQ_STS, 8'h00);
        smp(-90, 0, 0, 1'b0);
        wr(`VCD_IDX_INITX_MSB, 8'hff);
        rd(`VCD_IDX_INITX_MSB, 8'h3f);
        wr(`VCD_IDX_INITX_LSB, 8'h38);
        wr(`VCD_IDX_CNT, 8'h00);
        wr(`VCD_IDX_IRQ_EN, 8'h01);
        wr(`VCD_IDX_CFG, 8'h68);
        smp(-90, 0, 0, 1'b1);
        iq(1'b1);
        rd(`VCD_IDX_IRQ_STS, 8'h01);
        smp(-90, 0, 0, 1'b1);
        wr(`VCD_IDX_IRQ_EN, 8'h00);
        iq(1'b0);
        rd(`VCD_IDX_INT_SRC, 8'h02);
        fl(1'b0);
        smp(-90, 0, 0, 1'b0);
        rd(`VCD_IDX_IRQ_STS, 8'h03);
        wr(`VCD_IDX_IRQ_EN, 8'h02);
        iq(1'b1);
        wr(`VCD_IDX_IRQ_CLR, 8'h02);
        iq(1'b0);
        wr(`VCD_IDX_IRQ_CLR, 8'h03);
        rd(`VCD_IDX_IRQ_STS, 8'h00);
        $display("test latch done");

        wr(`VCD_IDX_CFG, 8'h00);
        wr(`VCD_IDX_INITX_MSB, 8'h00);
        wr(`VCD_IDX_INITX_LSB, 8'h00);
        wr(`VCD_IDX_CFG, 8'h38);
        smp(50, 0, 0, 1'b0);
        wr(`VCD_IDX_INITX_LSB, 8'hc8);
        smp(50, 0, 0, 1'b1);
        smp_x <= 14'h0c8;
        repeat (4) @(posedge aclk);
        fl(1'b1);
        wr(`VCD_IDX_CFG, 8'h30);
        fl(1'b0);
        smp(50, 0, 0, 1'b0);
        $display("test runtime done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
